// File: dlc_pkg.sv
// Notes on behaviour
// - Five-bit level code picks one of 32 levels.
// - Output is low plus span times code/32.
// - Low-power select one drops low, zero drops high.
// - Disabled, select one, code ones: high source out.
// - Disabled, select zero, code zeros: low source out.
// - Pin carries level only while pin enable set.
// - Routed pin loses digital driver and input detector.
// - Digital read of routed pin returns zero.
// - Wake from sleep leaves main control untouched.
// - Reset clears enable, pin routing and level code.
// - Converter enable is main control bit 7.
// - Positive source field bits 3-2, code 11 reserved.
// - Level register bits 4-0, bits 7-5 read zero.
// - Main control bits 4 and 1 read zero.
package dlc_pkg;

  // ==========================================================================
  // Bus geometry and register map
  // ==========================================================================
  localparam int unsigned DLC_AW           = 8;
  localparam int unsigned DLC_DW           = 32;
  localparam logic [7:0]  DLC_OFS_MAIN     = 8'h00;
  localparam logic [7:0]  DLC_OFS_LEVEL    = 8'h04;
  localparam logic [7:0]  DLC_OFS_STATUS   = 8'h08;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int unsigned DLC_EN_BIT       = 7;
  localparam int unsigned DLC_LPS_BIT      = 6;
  localparam int unsigned DLC_OE_BIT       = 5;
  localparam int unsigned DLC_PSS_LSB      = 2;
  localparam int unsigned DLC_NSS_BIT      = 0;
  localparam int unsigned DLC_CODE_W       = 5;
  localparam int unsigned DLC_LEVELS       = 32;
  localparam logic [7:0]  DLC_MAIN_RST     = 8'h00;
  localparam logic [7:0]  DLC_LEVEL_RST    = 8'h00;
  localparam logic [4:0]  DLC_CODE_ONES    = 5'h1F;
  localparam logic [4:0]  DLC_CODE_ZEROS   = 5'h00;
  localparam int unsigned DLC_STAT_VAL_LSB = 16;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    DLC_PSS_SUPPLY    = 2'h0,
    DLC_PSS_EXT_REF   = 2'h1,
    DLC_PSS_FIXED_REF = 2'h2,
    DLC_PSS_RSVD      = 2'h3
  } dlc_pss_t;

  typedef struct packed {
    logic     en;
    logic     lps;
    logic     oe;
    dlc_pss_t pss;
    logic     nss;
  } dlc_ctrl_t;

  typedef enum logic {
    DLC_BUS_IDLE,
    DLC_BUS_ACK
  } dlc_bus_st_t;

endpackage : dlc_pkg

// File: dlc_sync.sv
`timescale 1ns/1ps
module dlc_sync (
  input  wire logic clk_i,  // System clock.
  input  wire logic rst_i,  // Synchronous reset, active high.
  input  wire logic ce_i,   // Clock enable.
  input  wire logic d_i,    // Asynchronous level.
  output logic      q_o     // Level in the clock domain.
);
  import dlc_pkg::*;

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // ==========================================================================
  // Two-stage synchroniser
  // ==========================================================================
  // Only the second stage reads the first, so metastability cannot leak.
  always_comb begin
    meta_d = ce_i ? d_i : meta_q;
    sync_d = ce_i ? meta_q : sync_q;
  end

  // Both stages clear on reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;

endmodule : dlc_sync

// File: dlc_ladder.sv
`timescale 1ns/1ps
module dlc_ladder #(
  parameter int unsigned VW = 10
) (
  input  wire logic               clk_i,         // System clock.
  input  wire logic               rst_i,         // Synchronous reset, active high.
  input  wire logic               ce_i,          // Clock enable.
  input  wire dlc_pkg::dlc_ctrl_t ctrl_i,        // Main control fields.
  input  wire logic [4:0]         level_code_i,  // Ladder tap code.
  input  wire logic [VW-1:0]      high_value_i,  // Selected high source value.
  input  wire logic [VW-1:0]      low_value_i,   // Selected low source value.
  output logic      [VW-1:0]      level_value_o  // Modelled output level.
);
  import dlc_pkg::*;

  logic signed [VW:0]   diff;
  logic signed [VW+6:0] prod;
  logic signed [VW+6:0] scaled;
  logic signed [VW+1:0] sum;
  logic        [VW-1:0] value_d;
  logic        [VW-1:0] value_q;

  // ==========================================================================
  // Ladder arithmetic
  // ==========================================================================
  // The span is signed so a high source below the low one still lands between them.
  always_comb begin
    diff    = $signed({1'b0, high_value_i}) - $signed({1'b0, low_value_i});
    prod    = diff * $signed({1'b0, level_code_i});
    scaled  = prod >>> DLC_CODE_W;
    sum     = $signed({2'b00, low_value_i}) + scaled[VW+1:0];
    value_d = sum[VW-1:0];
    // A stopped ladder carries no current, so every tap sits at the end still connected.
    if (!ctrl_i.en) begin
      value_d = ctrl_i.lps ? high_value_i : low_value_i;
    end
    if (!ce_i) begin
      value_d = value_q;
    end
  end

  // Output level register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_q <= '0;
    end else begin
      value_q <= value_d;
    end
  end

  assign level_value_o = value_q;

endmodule : dlc_ladder

// File: dlc_top.sv
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module dlc_top #(
  parameter int unsigned VW = 10
) (
  input  wire logic                       clk_i,           // System clock, 100 MHz.
  input  wire logic                       rst_i,           // Device reset, active high.
  input  wire logic                       ce_i,            // Clock enable, freezes state.
  // Wishbone classic slave.
  input  wire logic                       wb_cyc_i,        // Bus cycle.
  input  wire logic                       wb_stb_i,        // Strobe.
  input  wire logic                       wb_we_i,         // Write enable.
  input  wire logic [dlc_pkg::DLC_AW-1:0] wb_adr_i,        // Byte address.
  input  wire logic [3:0]                 wb_sel_i,        // Byte selects.
  input  wire logic [dlc_pkg::DLC_DW-1:0] wb_dat_i,        // Write data.
  output logic      [dlc_pkg::DLC_DW-1:0] wb_dat_o,        // Read data.
  output logic                            wb_ack_o,        // Acknowledge.
  // Sleep and wake indications from the power manager.
  input  wire logic                       wake_i,          // Wake from sleep pulse.
  // Ladder source values from the analog front end.
  input  wire logic [VW-1:0]              supply_value_i,  // Supply rail value.
  input  wire logic [VW-1:0]              ext_high_i,      // External high reference.
  input  wire logic [VW-1:0]              fixed_ref_i,     // Buffered fixed reference.
  input  wire logic [VW-1:0]              ext_low_i,       // External low reference.
  // Ladder switch controls.
  output logic                            conv_enable_o,   // Ladder powered.
  output logic      [2:0]                 high_sel_o,      // High source switches, one-hot.
  output logic      [1:0]                 low_sel_o,       // Low source switches, one-hot.
  output logic      [4:0]                 level_code_o,    // Tap select code.
  output logic      [VW-1:0]              level_value_o,   // Modelled output level.
  // Reference output pin.
  input  wire logic                       port_out_i,      // Port data for the pin.
  input  wire logic                       port_oe_i,       // Port drive enable.
  input  wire logic                       pad_in_i,        // Raw level at the pad.
  output logic                            pad_out_o,       // Digital drive level.
  output logic                            pad_oe_o,        // Digital drive enable.
  output logic                            pad_detect_en_o, // Input threshold detector on.
  output logic                            pad_analog_o,    // Level routed to the pad.
  output logic                            port_in_o        // Digital read of the pin.
);
  import dlc_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // The status word holds the level in its upper half, so the width is capped.
  generate
    if (VW < 2 || VW > 16) begin : g_bad_vw
      $error("dlc_top: VW must lie between 2 and 16");
    end
  endgenerate

  // ==========================================================================
  // Declarations
  // ==========================================================================
  dlc_bus_st_t         bus_st_q;
  dlc_bus_st_t         bus_st_d;
  logic [DLC_DW-1:0]   rdata_q;
  logic [DLC_DW-1:0]   rdata_d;
  logic                req;
  logic                wr_commit;
  logic                hit_main;
  logic                hit_level;
  logic                hit_status;

  dlc_ctrl_t           ctrl_q;
  dlc_ctrl_t           ctrl_d;
  logic [4:0]          code_q;
  logic [4:0]          code_d;
  logic [7:0]          main_rd;
  logic [7:0]          level_rd;
  logic [DLC_DW-1:0]   status_rd;

  logic [VW-1:0]       high_value;
  logic [VW-1:0]       low_value;
  logic                high_conn;
  logic                low_conn;
  logic                clamp_cfg;
  logic [2:0]          high_sel_q;
  logic [2:0]          high_sel_d;
  logic [1:0]          low_sel_q;
  logic [1:0]          low_sel_d;

  logic                pad_in_sync;
  logic                pad_out_q;
  logic                pad_out_d;
  logic                pad_oe_q;
  logic                pad_oe_d;
  logic                detect_q;
  logic                detect_d;
  logic                analog_q;
  logic                analog_d;
  logic                port_in_q;
  logic                port_in_d;
  logic [VW-1:0]       level_value;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // A request is live while cycle and strobe stand together.
  assign req        = wb_cyc_i && wb_stb_i;
  // The write lands on the edge where the master sees the acknowledge.
  assign wr_commit  = req && wb_we_i && (bus_st_q == DLC_BUS_ACK) && ce_i;

  // Word-aligned decode; the two low address bits are ignored.
  always_comb begin
    hit_main   = 1'b0;
    hit_level  = 1'b0;
    hit_status = 1'b0;
    if (wb_adr_i[DLC_AW-1:2] == DLC_OFS_MAIN[DLC_AW-1:2]) begin
      hit_main = 1'b1;
    end else if (wb_adr_i[DLC_AW-1:2] == DLC_OFS_LEVEL[DLC_AW-1:2]) begin
      hit_level = 1'b1;
    end else if (wb_adr_i[DLC_AW-1:2] == DLC_OFS_STATUS[DLC_AW-1:2]) begin
      hit_status = 1'b1;
    end
  end

  // ==========================================================================
  // Read views
  // ==========================================================================
  // Unimplemented positions are wired to zero rather than stored.
  always_comb begin
    main_rd                 = DLC_MAIN_RST;
    main_rd[DLC_EN_BIT]     = ctrl_q.en;
    main_rd[DLC_LPS_BIT]    = ctrl_q.lps;
    main_rd[DLC_OE_BIT]     = ctrl_q.oe;
    main_rd[DLC_PSS_LSB+:2] = ctrl_q.pss;
    main_rd[DLC_NSS_BIT]    = ctrl_q.nss;
    // Bits 4 and 1 stay at their zero default.
    level_rd                = DLC_LEVEL_RST;
    level_rd[4:0]           = code_q;
    status_rd               = '0;
    status_rd[0]            = analog_q;
    status_rd[1]            = high_conn;
    status_rd[2]            = low_conn;
    status_rd[3]            = clamp_cfg;
    status_rd[4]            = (ctrl_q.pss == DLC_PSS_RSVD);
    status_rd[5]            = ctrl_q.en;
    status_rd[DLC_STAT_VAL_LSB+:VW] = level_value;
  end

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  // One wait state: acknowledge follows the request by one cycle and drops after one.
  // Unmapped addresses are acknowledged with zero data so the master never hangs.
  always_comb begin
    bus_st_d = bus_st_q;
    rdata_d  = rdata_q;
    if (ce_i) begin
      case (bus_st_q)
        DLC_BUS_IDLE: begin
          if (req) begin
            bus_st_d = DLC_BUS_ACK;
            rdata_d  = '0;
            if (!wb_we_i) begin
              if (hit_main) begin
                rdata_d = {24'h000000, main_rd};
              end else if (hit_level) begin
                rdata_d = {24'h000000, level_rd};
              end else if (hit_status) begin
                rdata_d = status_rd;
              end
            end
          end
        end
        DLC_BUS_ACK: begin
          bus_st_d = DLC_BUS_IDLE;
        end
        default: begin
          bus_st_d = DLC_BUS_IDLE;
        end
      endcase
    end
  end

  // Handshake state register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st_q <= DLC_BUS_IDLE;
      rdata_q  <= '0;
    end else begin
      bus_st_q <= bus_st_d;
      rdata_q  <= rdata_d;
    end
  end

  assign wb_ack_o = (bus_st_q == DLC_BUS_ACK) && req;
  assign wb_dat_o = rdata_q;

  // ==========================================================================
  // Control registers
  // ==========================================================================
  // Only a bus write or reset changes them; the wake pulse is deliberately not
  // an input to this logic, so waking from sleep keeps the settings.
  always_comb begin
    ctrl_d = ctrl_q;
    code_d = code_q;
    if (wr_commit && wb_sel_i[0]) begin
      if (hit_main) begin
        ctrl_d.en  = wb_dat_i[DLC_EN_BIT];
        ctrl_d.lps = wb_dat_i[DLC_LPS_BIT];
        ctrl_d.oe  = wb_dat_i[DLC_OE_BIT];
        ctrl_d.pss = dlc_pss_t'(wb_dat_i[DLC_PSS_LSB+:2]);
        ctrl_d.nss = wb_dat_i[DLC_NSS_BIT];
      end else if (hit_level) begin
        code_d = wb_dat_i[DLC_CODE_W-1:0];
      end
    end
  end

  // Reset clears every stored field, including the enable, routing and code.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= dlc_ctrl_t'(6'h00);
      code_q <= DLC_CODE_ZEROS;
    end else begin
      ctrl_q <= ctrl_d;
      code_q <= code_d;
    end
  end

  // ==========================================================================
  // Ladder source selection
  // ==========================================================================
  // The reserved positive code selects no source; the ladder top then floats to zero.
  always_comb begin
    high_value = '0;
    high_sel_d = 3'h0;
    case (ctrl_q.pss)
      DLC_PSS_SUPPLY: begin
        high_value = supply_value_i;
        high_sel_d = 3'h1;
      end
      DLC_PSS_EXT_REF: begin
        high_value = ext_high_i;
        high_sel_d = 3'h2;
      end
      DLC_PSS_FIXED_REF: begin
        high_value = fixed_ref_i;
        high_sel_d = 3'h4;
      end
      default: begin
        high_value = '0;
        high_sel_d = 3'h0;
      end
    endcase
    low_value = ctrl_q.nss ? ext_low_i : '0;
    low_sel_d = ctrl_q.nss ? 2'h2 : 2'h1;
    // Both ends stay connected while running; stopped, one end is cut to save power.
    high_conn = ctrl_q.en || ctrl_q.lps;
    low_conn  = ctrl_q.en || !ctrl_q.lps;
    if (!high_conn) begin
      high_sel_d = 3'h0;
    end
    if (!low_conn) begin
      low_sel_d = 2'h0;
    end
    if (!ce_i) begin
      high_sel_d = high_sel_q;
      low_sel_d  = low_sel_q;
    end
    // Flags the two least-power clamp settings for software to read back.
    clamp_cfg = !ctrl_q.en && ((ctrl_q.lps && code_q == DLC_CODE_ONES) ||
                               (!ctrl_q.lps && code_q == DLC_CODE_ZEROS));
  end

  // Switch drive registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_sel_q <= 3'h0;
      low_sel_q  <= 2'h0;
    end else begin
      high_sel_q <= high_sel_d;
      low_sel_q  <= low_sel_d;
    end
  end

  assign high_sel_o    = high_sel_q;
  assign low_sel_o     = low_sel_q;
  assign conv_enable_o = ctrl_q.en;
  assign level_code_o  = code_q;

  // Output level model.
  dlc_ladder #(
    .VW            (VW)
  ) u_ladder (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .ctrl_i        (ctrl_q),
    .level_code_i  (code_q),
    .high_value_i  (high_value),
    .low_value_i   (low_value),
    .level_value_o (level_value)
  );

  assign level_value_o = level_value;

  // ==========================================================================
  // Reference output pin
  // ==========================================================================
  // The pad level is asynchronous, so it is synchronised before the read path.
  dlc_sync u_pad_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pad_in_i),
    .q_o   (pad_in_sync)
  );

  // Routing takes the pin from the port entirely; a digital driver would fight
  // the weak ladder output, which is why it is forced off.
  always_comb begin
    analog_d  = ctrl_q.oe;
    pad_out_d = ctrl_q.oe ? 1'b0 : port_out_i;
    pad_oe_d  = ctrl_q.oe ? 1'b0 : port_oe_i;
    detect_d  = !ctrl_q.oe;
    port_in_d = ctrl_q.oe ? 1'b0 : pad_in_sync;
    if (!ce_i) begin
      analog_d  = analog_q;
      pad_out_d = pad_out_q;
      pad_oe_d  = pad_oe_q;
      detect_d  = detect_q;
      port_in_d = port_in_q;
    end
  end

  // Pin control registers; reset leaves the pin digital and unrouted.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_q  <= 1'b0;
      pad_out_q <= 1'b0;
      pad_oe_q  <= 1'b0;
      detect_q  <= 1'b1;
      port_in_q <= 1'b0;
    end else begin
      analog_q  <= analog_d;
      pad_out_q <= pad_out_d;
      pad_oe_q  <= pad_oe_d;
      detect_q  <= detect_d;
      port_in_q <= port_in_d;
    end
  end

  assign pad_analog_o    = analog_q;
  assign pad_out_o       = pad_out_q;
  assign pad_oe_o        = pad_oe_q;
  assign pad_detect_en_o = detect_q;
  assign port_in_o       = port_in_q;

endmodule : dlc_top

// File: dlc_properties.sv
`timescale 1ns/1ps
module dlc_properties
  import dlc_pkg::*;
(
  input wire logic              clk_i,           // System clock.
  input wire logic              rst_i,           // Reset, active high.
  input wire logic              ce_i,            // Clock enable.
  input wire logic              wb_cyc_i,        // Bus cycle.
  input wire logic              wb_stb_i,        // Strobe.
  input wire logic              wb_we_i,         // Write enable.
  input wire logic [DLC_AW-1:0] wb_adr_i,        // Byte address.
  input wire logic [3:0]        wb_sel_i,        // Byte selects.
  input wire logic [DLC_DW-1:0] wb_dat_i,        // Write data.
  input wire logic [DLC_DW-1:0] wb_dat_o,        // Read data.
  input wire logic              wb_ack_o,        // Acknowledge.
  input wire logic              conv_enable_o,   // Ladder powered.
  input wire logic [2:0]        high_sel_o,      // High switches.
  input wire logic [1:0]        low_sel_o,       // Low switches.
  input wire logic [4:0]        level_code_o,    // Tap code.
  input wire logic              pad_oe_o,        // Pad drive enable.
  input wire logic              pad_detect_en_o, // Input detector on.
  input wire logic              pad_analog_o,    // Level routed.
  input wire logic              port_in_o        // Digital read.
);
  // ==========================================================================
  // Decoded bus events
  // ==========================================================================
  // Writes are judged at the ack edge, where the register takes them.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire main_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == DLC_OFS_MAIN;
  wire lvl_wr  = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == DLC_OFS_LEVEL;
  wire rd_ack  = wb_ack_o && !wb_we_i;

  // ==========================================================================
  // Properties
  // ==========================================================================
  // Reset is checked with the disable switched off, since it is the cause.
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack did not follow a request by one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed high");
  enable_follow_a: assert property (main_wr |=> conv_enable_o == $past(wb_dat_i[7]))
    else $error("enable does not follow bit 7");
  code_follow_a: assert property (lvl_wr |=> level_code_o == $past(wb_dat_i[4:0]))
    else $error("level code does not follow write");
  route_follow_a: assert property (
    main_wr |=> ##1 pad_analog_o == $past(wb_dat_i[5], 2))
    else $error("pin routing does not follow bit 5");
  pin_override_a: assert property (pad_analog_o |-> !pad_oe_o && !pad_detect_en_o)
    else $error("routed pin keeps digital buffer");
  read_zero_a: assert property (pad_analog_o |-> !port_in_o)
    else $error("routed pin reads one");
  source_cut_a: assert property (
    !$past(conv_enable_o) |-> high_sel_o == 3'h0 || low_sel_o == 2'h0)
    else $error("disabled ladder has both ends connected");
  reset_clear_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !conv_enable_o && level_code_o == 5'h00 && !pad_analog_o)
    else $error("reset left converter state");
  level_rsvd_a: assert property (
    rd_ack && wb_adr_i == DLC_OFS_LEVEL |-> wb_dat_o[7:5] == 3'h0)
    else $error("level bits 7-5 read nonzero");
  main_rsvd_a: assert property (
    rd_ack && wb_adr_i == DLC_OFS_MAIN |-> !wb_dat_o[4] && !wb_dat_o[1])
    else $error("main bits 4 or 1 read nonzero");
  route_c: cover property (pad_analog_o);
  clamp_c: cover property (!conv_enable_o && low_sel_o == 2'h0 && high_sel_o != 3'h0);
  write_c: cover property (main_wr ##3 lvl_wr);
endmodule : dlc_properties

bind dlc_top dlc_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .conv_enable_o(conv_enable_o), .high_sel_o(high_sel_o), .low_sel_o(low_sel_o),
  .level_code_o(level_code_o), .pad_oe_o(pad_oe_o), .pad_detect_en_o(pad_detect_en_o),
  .pad_analog_o(pad_analog_o), .port_in_o(port_in_o));

// File: dlc_top_test.sv
`timescale 1ns/1ps
module dlc_top_test;
  import dlc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic wake_i = 1'b0, port_out_i = 1'b0, port_oe_i = 1'b0, pad_in_i = 1'b0, ce_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdv;
  logic [9:0] sup_v = 10'h280, exh_v = 10'h140, fix_v = 10'h3C0, exl_v = 10'h040, lvl_v;
  logic wb_ack_o, en_o, pout_o, poe_o, det_o, ana_o, pin_o;
  logic [2:0] hs_o;
  logic [1:0] ls_o;
  logic [4:0] code_o;
  int failures = 0, checks_done = 0;

  // ==========================================================================
  // Clock, device and helpers
  // ==========================================================================
  always #5 clk_i = ~clk_i;
  dlc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wake_i(wake_i),
    .supply_value_i(sup_v), .ext_high_i(exh_v), .fixed_ref_i(fix_v), .ext_low_i(exl_v),
    .conv_enable_o(en_o), .high_sel_o(hs_o), .low_sel_o(ls_o), .level_code_o(code_o),
    .level_value_o(lvl_v), .port_out_i(port_out_i), .port_oe_i(port_oe_i),
    .pad_in_i(pad_in_i), .pad_out_o(pout_o), .pad_oe_o(poe_o), .pad_detect_en_o(det_o),
    .pad_analog_o(ana_o), .port_in_o(pin_o));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // One classic cycle; the leading edge keeps cyc low for a cycle between calls.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string nm);
    wb(1'b0, adr, 32'h0);
    chk(nm, exp, rdv);
  endtask : rd_chk

  // Registered outputs are read a step after the edge so their updates have landed.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_ladder();
    int hi;
    for (int p = 0; p < 4; p++) begin
      hi = (p == 0) ? 640 : (p == 1) ? 320 : (p == 2) ? 960 : 0;
      wb(1'b1, DLC_OFS_MAIN, 32'h81 | (p << 2));
      wb(1'b1, DLC_OFS_LEVEL, 32'h10);
      settle(3);
      chk("level", 64 + ((hi - 64) * 16) / 32, lvl_v);
      chk("high_sel", (p < 3) ? (1 << p) : 0, hs_o);
    end
    wb(1'b1, DLC_OFS_MAIN, 32'h81);
    wb(1'b1, DLC_OFS_LEVEL, 32'h1F);
    settle(3);
    chk("level_top", 622, lvl_v);
    chk("code", 31, code_o);
  endtask : t_ladder

  task automatic t_clamp();
    wb(1'b1, DLC_OFS_MAIN, 32'h48);
    settle(3);
    chk("high_clamp", 960, lvl_v);
    chk("low_cut", 5'h10, {hs_o, ls_o});
    wb(1'b1, DLC_OFS_MAIN, 32'h00);
    wb(1'b1, DLC_OFS_LEVEL, 32'h00);
    settle(3);
    chk("low_clamp", 0, lvl_v);
    chk("high_cut", 5'h01, {hs_o, ls_o});
    rd_chk(DLC_OFS_STATUS, 32'h0C, "status");
  endtask : t_clamp

  task automatic t_rsvd();
    wb(1'b1, DLC_OFS_MAIN, 32'hFF);
    rd_chk(DLC_OFS_MAIN, 32'hED, "main_ff");
    wb(1'b1, DLC_OFS_LEVEL, 32'hFF);
    rd_chk(DLC_OFS_LEVEL, 32'h1F, "level_ff");
    wb(1'b1, 8'h0C, 32'hFF);
    rd_chk(8'h0C, 32'h0, "unmapped");
  endtask : t_rsvd

  task automatic t_pin();
    pad_in_i   <= 1'b1;
    port_out_i <= 1'b1;
    port_oe_i  <= 1'b1;
    wb(1'b1, DLC_OFS_MAIN, 32'h20);
    settle(4);
    chk("analog", 1, ana_o);
    chk("drive", 3'h0, {pout_o, poe_o, det_o});
    chk("read_routed", 0, pin_o);
    wb(1'b1, DLC_OFS_MAIN, 32'h00);
    settle(4);
    chk("read_free", 5'h1E, {pin_o, pout_o, poe_o, det_o, ana_o});
    // A low enable freezes the pad read path; it resumes once enable returns.
    @(posedge clk_i);
    ce_i     <= 1'b0;
    pad_in_i <= 1'b0;
    settle(4);
    chk("read_frozen", 1, pin_o);
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle(4);
    chk("read_thawed", 0, pin_o);
  endtask : t_pin

  task automatic t_wake_reset();
    wb(1'b1, DLC_OFS_MAIN, 32'hA5);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    rd_chk(DLC_OFS_MAIN, 32'hA5, "main_wake");
    chk("enable", 1, en_o);
    wb(1'b1, DLC_OFS_LEVEL, 32'h15);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(DLC_OFS_MAIN, 32'h0, "main_rst");
    rd_chk(DLC_OFS_LEVEL, 32'h0, "level_rst");
  endtask : t_wake_reset

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Generous against the fewer than two hundred cycles that the scenarios need.
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(DLC_OFS_MAIN, 32'h0, "main_init");
    chk("detect_init", 1, det_o);
    t_ladder();
    t_clamp();
    t_rsvd();
    t_pin();
    t_wake_reset();
    tally_and_finish();
  end
endmodule : dlc_top_test
